//--- p1pm_pkg.sv
// constants for the port 1 upper pin mode control block
package p1pm_pkg;
  // ------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------
  localparam int P1PM_AW = 12;
  localparam logic [7:0] P1PM_IDX_DATA = 8'hc1;
  localparam logic [7:0] P1PM_IDX_UPPER = 8'hd3;
  localparam logic [7:0] P1PM_IDX_MID = 8'hd4;
  localparam logic [7:0] P1PM_IDX_PULLUP = 8'hd6;
  localparam logic [11:0] P1PM_ADR_DATA = {2'b00, P1PM_IDX_DATA, 2'b00};
  localparam logic [11:0] P1PM_ADR_UPPER = {2'b00, P1PM_IDX_UPPER, 2'b00};
  localparam logic [11:0] P1PM_ADR_MID = {2'b00, P1PM_IDX_MID, 2'b00};
  localparam logic [11:0] P1PM_ADR_PULLUP = {2'b00, P1PM_IDX_PULLUP, 2'b00};
  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] P1PM_RST_UPPER = 8'h55;
  localparam logic [7:0] P1PM_RST_MID = 8'h20;
  localparam logic [7:0] P1PM_RST_DATA = 8'hf8;
  localparam logic [7:0] P1PM_RST_PULLUP = 8'h00;
  localparam logic [7:0] P1PM_MID_WR_MASK = 8'hfc;
  // ------------------------------------------------------------
  // pins and field positions
  // ------------------------------------------------------------
  localparam int P1PM_NPIN = 6;
  localparam int P1PM_PIN_LSB = 2;
  localparam int P1PM_UP_P7_LSB = 6;
  localparam int P1PM_UP_P6_LSB = 4;
  localparam int P1PM_UP_P5_LSB = 2;
  localparam int P1PM_UP_P4_LSB = 0;
  localparam int P1PM_MID_P3_LSB = 5;
  localparam int P1PM_MID_P2_LSB = 2;
  // ------------------------------------------------------------
  // mode codes
  // ------------------------------------------------------------
  localparam logic [1:0] P1PM_M2_IN = 2'h0;
  localparam logic [1:0] P1PM_M2_OD = 2'h1;
  localparam logic [1:0] P1PM_M2_ALT = 2'h2;
  localparam logic [1:0] P1PM_M2_PP = 2'h3;
  localparam logic [2:0] P1PM_M3_IN = 3'h0;
  localparam logic [2:0] P1PM_M3_OD = 3'h1;
  localparam logic [2:0] P1PM_M3_AN = 3'h2;
  localparam logic [2:0] P1PM_M3_PWM = 3'h3;
  localparam logic [2:0] P1PM_M3_BUZ = 3'h5;
  localparam logic [2:0] P1PM_M3_PP = 3'h7;
endpackage : p1pm_pkg

//--- p1pm_sync.sv
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
module p1pm_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side
  input wire logic [WIDTH-1:0] async_in,
  // filtered level
  output logic [WIDTH-1:0] level_ff
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule : p1pm_sync

//--- p1pm_apb_slave.sv
// apb slave front end: decode, write strobes, read data
`timescale 1ns/100ps
module p1pm_apb_slave
  import p1pm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register values for reads
  input wire logic [7:0] rd_upper,
  input wire logic [7:0] rd_mid,
  input wire logic [7:0] rd_pullup,
  input wire logic [7:0] rd_data,
  // write strobes
  output logic wr_upper,
  output logic wr_mid,
  output logic wr_pullup,
  output logic wr_data,
  output logic [7:0] wdata8
);
  logic hit;
  logic [7:0] rsel;
  logic done;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rsel = 8'h00;
    if (paddr == P1PM_ADR_UPPER) begin
      rsel = rd_upper;
    end else if (paddr == P1PM_ADR_MID) begin
      rsel = rd_mid;
    end else if (paddr == P1PM_ADR_PULLUP) begin
      rsel = rd_pullup;
    end else if (paddr == P1PM_ADR_DATA) begin
      rsel = rd_data;
    end else begin
      hit = 1'b0;
    end
  end

  assign done = psel & penable & pready;
  assign wdata8 = pwdata[7:0];
  assign wr_upper = done & pwrite & (paddr == P1PM_ADR_UPPER);
  assign wr_mid = done & pwrite & (paddr == P1PM_ADR_MID);
  assign wr_pullup = done & pwrite & (paddr == P1PM_ADR_PULLUP);
  assign wr_data = done & pwrite & (paddr == P1PM_ADR_DATA);

  // ------------------------------------------------------------
  // answer in the first access cycle
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= ~hit;
      prdata <= {24'h00_0000, rsel};
    end else if (done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : p1pm_apb_slave

//--- p1pm_port1_upper_pin_mode.sv
// port 1 pins seven..two mode control, pad drive and register file
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module p1pm_port1_upper_pin_mode
  import p1pm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads, index 0 is pin two
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n,
  output logic [5:0] port1_pullup_enable,
  // two-wire serial
  input wire logic twi_scl_out,
  input wire logic twi_scl_oe_n,
  output logic twi_scl_in,
  input wire logic twi_sda_out,
  input wire logic twi_sda_oe_n,
  output logic twi_sda_in,
  // asynchronous serial
  input wire logic serial_txd,
  input wire logic serial_rxd_m0_out,
  input wire logic serial_rxd_m0_oe_n,
  output logic serial_rxd_in,
  // pwm, buzzer, analog and external interrupts
  input wire logic pwm_ch4_out,
  input wire logic pwm_ch3_out,
  input wire logic buzzer_out,
  output logic analog_channel_eight,
  output logic analog_channel_seven,
  output logic ext_irq_nine,
  output logic ext_irq_eight
);
  localparam int K7 = 5;
  localparam int K6 = 4;
  localparam int K5 = 3;
  localparam int K4 = 2;
  localparam int K3 = 1;
  localparam int K2 = 0;

  logic [7:0] upper_ff;
  logic [7:0] mid_ff;
  logic [7:0] pullup_ff;
  logic [7:0] data_ff;
  logic [7:0] nxt_upper;
  logic [7:0] nxt_mid;
  logic [7:0] nxt_pullup;
  logic [7:0] nxt_data;
  logic [5:0] nxt_out;
  logic [5:0] nxt_oe_n;
  logic [5:0] pin_lvl;
  logic [7:0] rd_data;
  logic wr_upper;
  logic wr_mid;
  logic wr_pullup;
  logic wr_data;
  logic [7:0] wdata8;
  logic [1:0] f7;
  logic [1:0] f6;
  logic [1:0] f5;
  logic [1:0] f4;
  logic [2:0] f3;
  logic [2:0] f2;

  // ------------------------------------------------------------
  // drive helpers, result is {oe_n, out}
  // ------------------------------------------------------------
  function automatic logic [1:0] drv2(input logic [1:0] code, input logic dat,
                                      input logic alt_o, input logic alt_oe_n);
    logic [1:0] r;
    r = {1'b1, dat};
    case (code)
      P1PM_M2_OD: r = {dat, 1'b0};
      P1PM_M2_PP: r = {1'b0, dat};
      P1PM_M2_ALT: r = {alt_oe_n, alt_o};
      default: r = {1'b1, dat};
    endcase
    return r;
  endfunction : drv2

  function automatic logic [1:0] drv3(input logic [2:0] code, input logic dat,
                                      input logic pwm, input logic buz, input logic has_buz);
    logic [1:0] r;
    r = {1'b1, dat};
    if (code == P1PM_M3_OD) begin
      r = {dat, 1'b0};
    end else if (code == P1PM_M3_PWM) begin
      r = {1'b0, pwm};
    end else if (has_buz && code == P1PM_M3_BUZ) begin
      r = {1'b0, buz};
    end else if (has_buz && code == P1PM_M3_PP) begin
      r = {1'b0, dat};
    end else if (!has_buz && code[2]) begin
      r = {1'b0, dat};
    end
    return r;
  endfunction : drv3

  // ------------------------------------------------------------
  // bus front end and input synchroniser
  // ------------------------------------------------------------
  p1pm_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rd_upper(upper_ff),
    .rd_mid(mid_ff),
    .rd_pullup(pullup_ff),
    .rd_data(rd_data),
    .wr_upper(wr_upper),
    .wr_mid(wr_mid),
    .wr_pullup(wr_pullup),
    .wr_data(wr_data),
    .wdata8(wdata8)
  );

  p1pm_sync #(.WIDTH(P1PM_NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_in),
    .level_ff(pin_lvl)
  );

  assign twi_scl_in = pin_lvl[K7];
  assign twi_sda_in = pin_lvl[K6];
  assign serial_rxd_in = pin_lvl[K4];

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_comb begin
    nxt_upper = wr_upper ? wdata8 : upper_ff;
    nxt_mid = wr_mid ? (wdata8 & P1PM_MID_WR_MASK) : mid_ff;
    nxt_pullup = wr_pullup ? wdata8 : pullup_ff;
    nxt_data = wr_data ? wdata8 : data_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_ff <= P1PM_RST_UPPER;
      mid_ff <= P1PM_RST_MID;
    end else begin
      upper_ff <= nxt_upper;
      mid_ff <= nxt_mid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_ff <= P1PM_RST_PULLUP;
      data_ff <= P1PM_RST_DATA;
    end else begin
      pullup_ff <= nxt_pullup;
      data_ff <= nxt_data;
    end
  end

  // ------------------------------------------------------------
  // pad drive, computed from the incoming mode values
  // ------------------------------------------------------------
  assign f7 = nxt_upper[P1PM_UP_P7_LSB +: 2];
  assign f6 = nxt_upper[P1PM_UP_P6_LSB +: 2];
  assign f5 = nxt_upper[P1PM_UP_P5_LSB +: 2];
  assign f4 = nxt_upper[P1PM_UP_P4_LSB +: 2];
  assign f3 = nxt_mid[P1PM_MID_P3_LSB +: 3];
  assign f2 = nxt_mid[P1PM_MID_P2_LSB +: 3];

  always_comb begin
    {nxt_oe_n[K7], nxt_out[K7]} = drv2(f7, nxt_data[K7 + P1PM_PIN_LSB], twi_scl_out, twi_scl_oe_n);
    {nxt_oe_n[K6], nxt_out[K6]} = drv2(f6, nxt_data[K6 + P1PM_PIN_LSB], twi_sda_out, twi_sda_oe_n);
    {nxt_oe_n[K5], nxt_out[K5]} = drv2(f5, nxt_data[K5 + P1PM_PIN_LSB], serial_txd, 1'b0);
    {nxt_oe_n[K4], nxt_out[K4]} = drv2(f4, nxt_data[K4 + P1PM_PIN_LSB], serial_rxd_m0_out,
                                       serial_rxd_m0_oe_n);
    {nxt_oe_n[K3], nxt_out[K3]} = drv3(f3, nxt_data[K3 + P1PM_PIN_LSB], pwm_ch4_out, 1'b0, 1'b0);
    {nxt_oe_n[K2], nxt_out[K2]} = drv3(f2, nxt_data[K2 + P1PM_PIN_LSB], pwm_ch3_out, buzzer_out,
                                       1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= nxt_out;
      pin_oe_n <= nxt_oe_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_pullup_enable <= '0;
    end else begin
      port1_pullup_enable <= nxt_pullup[P1PM_PIN_LSB +: P1PM_NPIN];
    end
  end

  // ------------------------------------------------------------
  // analog selects and external interrupt inputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_channel_eight <= 1'b0;
      analog_channel_seven <= 1'b0;
      ext_irq_nine <= 1'b0;
      ext_irq_eight <= 1'b0;
    end else begin
      analog_channel_eight <= (f3 == P1PM_M3_AN);
      analog_channel_seven <= (f2 == P1PM_M3_AN);
      ext_irq_nine <= (f3 == P1PM_M3_IN) & pin_lvl[K3];
      ext_irq_eight <= (f2 == P1PM_M3_IN) & pin_lvl[K2];
    end
  end

  // ------------------------------------------------------------
  // data read: pin level for input-mode pins
  // ------------------------------------------------------------
  always_comb begin
    rd_data = data_ff;
    if (upper_ff[P1PM_UP_P7_LSB +: 2] == P1PM_M2_IN) rd_data[K7 + P1PM_PIN_LSB] = pin_lvl[K7];
    if (upper_ff[P1PM_UP_P6_LSB +: 2] == P1PM_M2_IN) rd_data[K6 + P1PM_PIN_LSB] = pin_lvl[K6];
    if (upper_ff[P1PM_UP_P5_LSB +: 2] == P1PM_M2_IN) rd_data[K5 + P1PM_PIN_LSB] = pin_lvl[K5];
    if (upper_ff[P1PM_UP_P4_LSB +: 2] == P1PM_M2_IN) rd_data[K4 + P1PM_PIN_LSB] = pin_lvl[K4];
    if (mid_ff[P1PM_MID_P3_LSB +: 3] == P1PM_M3_IN) rd_data[K3 + P1PM_PIN_LSB] = pin_lvl[K3];
    if (mid_ff[P1PM_MID_P2_LSB +: 3] == P1PM_M3_IN) rd_data[K2 + P1PM_PIN_LSB] = pin_lvl[K2];
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_upper_reset_val: assert property (!$past(presetn) |-> upper_ff == 8'h55)
    else $error("upper mode register not 55h after reset");
  a_mid_reset_val: assert property (!$past(presetn) |-> mid_ff == 8'h20)
    else $error("middle mode register not 20h after reset");
  a_od_pin_five: assert property (upper_ff[3:2] == 2'b01 |-> pin_oe_n[3] == data_ff[5] && !pin_out[3])
    else $error("pin five open-drain drive wrong");
  a_pp_pin_seven: assert property (upper_ff[7:6] == 2'b11 |-> !pin_oe_n[5] && pin_out[5] == data_ff[7])
    else $error("pin seven push-pull drive wrong");
  a_scl_route_pin: assert property (upper_ff[7:6] == 2'b10 |->
      pin_out[5] == $past(twi_scl_out) && pin_oe_n[5] == $past(twi_scl_oe_n))
    else $error("pin seven not carrying serial clock");
  a_sda_route_pin: assert property (upper_ff[5:4] == 2'b10 |-> pin_out[4] == $past(twi_sda_out))
    else $error("pin six not carrying serial data");
  a_txd_route_pin: assert property (upper_ff[3:2] == 2'b10 |-> !pin_oe_n[3] && pin_out[3] == $past(serial_txd))
    else $error("pin five not driven by transmitter");
  a_rxd_input_pin: assert property (upper_ff[1:0] == 2'b00 |-> pin_oe_n[2])
    else $error("pin four driven while in input mode");
  a_pwm4_route_pin: assert property (mid_ff[7:5] == 3'b011 |-> !pin_oe_n[1] && pin_out[1] == $past(pwm_ch4_out))
    else $error("pin three not carrying pwm channel 4");
  a_buz_route_pin: assert property (mid_ff[4:2] == 3'b101 |-> !pin_oe_n[0] && pin_out[0] == $past(buzzer_out))
    else $error("pin two not carrying buzzer");
  a_pin2_unavail: assert property (mid_ff[4:2] inside {3'b100, 3'b110} |-> pin_oe_n[0])
    else $error("pin two driven by unavailable code");
  a_mid_unused_bits: assert property (mid_ff[1:0] == 2'b00)
    else $error("middle register low bits not zero");
  a_pullup_follow: assert property (wr_pullup |=> port1_pullup_enable == $past(wdata8[7:2]))
    else $error("pull-up enables did not follow write");
  a_mode_next_cycle: assert property (wr_upper && wdata8[7:6] == 2'b11 |=>
      upper_ff[7:6] == 2'b11 && !pin_oe_n[5])
    else $error("new mode not in effect after write");

  c_scl_alt: cover property (wr_upper && wdata8[7:6] == 2'b10);
  c_buzzer_sel: cover property (wr_mid && wdata8[4:2] == 3'b101);
  c_data_read: cover property (psel && penable && pready && !pwrite && paddr == P1PM_ADR_DATA);
  c_rxd_mode0: cover property (upper_ff[1:0] == 2'b10 && !pin_oe_n[2]);
  c_pin3_irq: cover property (ext_irq_nine);
endmodule : p1pm_port1_upper_pin_mode

//--- p1pm_pad_model.sv
// pad model: external drivers, pull-ups and floating lines of port 1 pins seven..two
`timescale 1ns/100ps
module p1pm_pad_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // device side
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] pullup_en,
  // external drivers
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  // pad level seen by the device
  output logic [5:0] pin_in
);
  logic flt_ff;
  // floating pads wander every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_ff <= 1'b0;
    end else begin
      flt_ff <= ~flt_ff;
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pullup_en[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = flt_ff ^ i[0];
      end
    end
  end
endmodule : p1pm_pad_model

//--- p1pm_port1_upper_pin_mode_bench.sv
// self-checking bench for the port 1 upper pin mode block
`timescale 1ns/100ps
module p1pm_port1_upper_pin_mode_bench
  import p1pm_pkg::*;
;
  localparam logic [7:0] DAT = 8'haf;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pin_in, pin_out, pin_oe_n, pullup_en, ext_en, ext_val;
  logic scl_out, scl_oe_n, scl_in, sda_out, sda_oe_n, sda_in, txd, m0_out, m0_oe_n, rxd_in;
  logic pwm4, pwm3, buz, an8, an7, irq9, irq8;
  logic [1:0] c2;
  logic [2:0] c3;
  logic [7:0] eu, alt;
  int n_errors = 0;
  int check_count = 0;

  always #25 pclk = ~pclk;

  p1pm_port1_upper_pin_mode dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .port1_pullup_enable(pullup_en),
    .twi_scl_out(scl_out), .twi_scl_oe_n(scl_oe_n), .twi_scl_in(scl_in), .twi_sda_out(sda_out),
    .twi_sda_oe_n(sda_oe_n), .twi_sda_in(sda_in), .serial_txd(txd), .serial_rxd_m0_out(m0_out),
    .serial_rxd_m0_oe_n(m0_oe_n), .serial_rxd_in(rxd_in), .pwm_ch4_out(pwm4), .pwm_ch3_out(pwm3),
    .buzzer_out(buz), .analog_channel_eight(an8), .analog_channel_seven(an7), .ext_irq_nine(irq9),
    .ext_irq_eight(irq8));

  p1pm_pad_model pad_u (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write edge settle before anyone looks at the pins
    @(negedge pclk);
  endtask : apb

  // pad view: released reads 10, driven reads 0 and the level
  function automatic logic [1:0] drv(input logic oe_n, input logic o);
    return {oe_n, o & ~oe_n};
  endfunction : drv

  function automatic logic [11:0] seen_pins();
    logic [11:0] s;
    for (int i = 0; i < 6; i++) begin
      s[2*i+:2] = drv(pin_oe_n[i], pin_out[i]);
    end
    return s;
  endfunction : seen_pins

  function automatic logic [1:0] exp_mid(input logic [2:0] c, input logic d, input logic p, input logic b,
                                         input logic hi);
    if (c == P1PM_M3_OD) return drv(d, 1'b0);
    if (c == P1PM_M3_PWM) return drv(1'b0, p);
    if (hi && c[2]) return drv(1'b0, d);
    if (c == P1PM_M3_PP) return drv(1'b0, d);
    if (c == P1PM_M3_BUZ) return drv(1'b0, b);
    return 2'b10;
  endfunction : exp_mid

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext_en = 6'h00;
    ext_val = 6'h00;
    // peripherals already enabled on their side
    {scl_out, scl_oe_n, sda_out, sda_oe_n, txd, m0_out, m0_oe_n} = 7'b0010010;
    {pwm4, pwm3, buz} = 3'b010;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, P1PM_ADR_UPPER, 8'h00);
    check(rd, 32'h55);
    apb(1'b0, P1PM_ADR_MID, 8'h00);
    check(rd, 32'h20);
    apb(1'b0, P1PM_ADR_DATA, 8'h00);
    check(rd, 32'hf8);
    check(32'(seen_pins()), 32'haaa);
    apb(1'b0, 12'h000, 8'h00);
    check({31'h0, err}, 32'h1);
    apb(1'b1, P1PM_ADR_PULLUP, 8'hdc);
    check({26'h0, pullup_en}, 32'h37);
    apb(1'b0, P1PM_ADR_PULLUP, 8'h00);
    check(rd, 32'hdc);
    apb(1'b1, P1PM_ADR_DATA, DAT);
    alt = {drv(scl_oe_n, scl_out), drv(sda_oe_n, sda_out), drv(1'b0, txd), drv(m0_oe_n, m0_out)};
    for (int k = 0; k < 4; k++) begin
      c2 = k[1:0];
      apb(1'b1, P1PM_ADR_UPPER, {4{c2}});
      for (int j = 0; j < 4; j++) begin
        case (c2)
          P1PM_M2_IN: eu[2*j+:2] = 2'b10;
          P1PM_M2_OD: eu[2*j+:2] = drv(DAT[j+4], 1'b0);
          P1PM_M2_PP: eu[2*j+:2] = drv(1'b0, DAT[j+4]);
          default: eu[2*j+:2] = alt[2*j+:2];
        endcase
      end
      check(32'(seen_pins()), {20'h0, eu, 4'b1010});
      apb(1'b0, P1PM_ADR_UPPER, 8'h00);
      check(rd, {24'h0, {4{c2}}});
    end
    for (int k = 0; k < 8; k++) begin
      c3 = k[2:0];
      // pwm, buzzer and push-pull must differ on codes 011 and 101
      @(posedge pclk);
      {pwm4, pwm3, buz} <= {k[2], k[2], ~k[2]};
      apb(1'b1, P1PM_ADR_MID, {c3, c3, 2'b11});
      check(32'(seen_pins() & 12'h00f), {28'h0, exp_mid(c3, DAT[3], pwm4, buz, 1'b1),
        exp_mid(c3, DAT[2], pwm3, buz, 1'b0)});
      repeat (5) @(negedge pclk);
      check({28'h0, an8, an7, irq9, irq8}, {28'h0, {2{c3 == P1PM_M3_AN}}, {2{c3 == P1PM_M3_IN}}});
      apb(1'b0, P1PM_ADR_MID, 8'h00);
      check(rd, {24'h0, c3, c3, 2'b00});
    end
    @(posedge pclk);
    ext_en <= 6'h3f;
    ext_val <= 6'b100101;
    apb(1'b1, P1PM_ADR_UPPER, 8'h00);
    apb(1'b1, P1PM_ADR_MID, 8'h00);
    repeat (5) @(negedge pclk);
    apb(1'b0, P1PM_ADR_DATA, 8'h00);
    check(rd, 32'h97);
    check({28'h0, an8, an7, irq9, irq8}, 32'h1);
    check({29'h0, scl_in, sda_in, rxd_in}, 32'h5);
    apb(1'b1, P1PM_ADR_UPPER, 8'hff);
    apb(1'b0, P1PM_ADR_DATA, 8'h00);
    check(rd, 32'ha7);
    final_report();
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    final_report();
  end
endmodule : p1pm_port1_upper_pin_mode_bench
